// *** logic/dad_alu.sv ***
`timescale 1ns/10ps
module dad_alu (
  // Operation select
  input  wire dad_pkg::dad_op_t    op,
  // Operand and incoming flags
  input  wire logic [7:0]          opnd,
  input  wire dad_pkg::dad_flags_t flags_in,
  // Result
  output logic [7:0]               result,
  output dad_pkg::dad_flags_t      flags_out
);
  import dad_pkg::*;

  logic [4:0] lo_sum;
  logic [4:0] hi_sum;

  always_comb begin
    lo_sum    = 5'h00;
    hi_sum    = 5'h00;
    result    = opnd;
    flags_out = flags_in;
    unique case (op)
      DAD_OP_NONE: begin
        result = opnd;
      end
      DAD_OP_DEC: begin
        result       = opnd - 8'h01;
        flags_out.c                = (opnd != 8'h00);
        flags_out.digit_carry_flag = (opnd[3:0] != 4'h0);
        flags_out.overflow_flag    = (opnd == DEC_OVF_SRC);
        flags_out.n  = result[7];
        flags_out.z  = (result == 8'h00);
      end
      DAD_OP_DADJ: begin
        lo_sum = {1'b0, opnd[3:0]};
        if (opnd[3:0] > BCD_MAX || flags_in.digit_carry_flag) begin
          lo_sum = lo_sum + {1'b0, BCD_FIX};
        end
        hi_sum = {1'b0, opnd[7:4]} + {4'h0, lo_sum[4]};
        if (hi_sum > {1'b0, BCD_MAX} || flags_in.c) begin
          hi_sum = hi_sum + {1'b0, BCD_FIX};
        end
        result = {hi_sum[3:0], lo_sum[3:0]};
        // Carry only ever sets here, never clears
        flags_out.c = flags_in.c | hi_sum[4];
      end
      default: begin
        result = opnd;
      end
    endcase
  end

endmodule

// *** logic/dad_core.sv ***
`timescale 1ns/10ps
// What this block does
// - Decrement reads operand in phase two, computes in three, writes in four.
// - Decrement sets carry, digit carry, negative, overflow, zero from operand minus one.
// - Destination bit 0 sends result to accumulator; 1 writes operand byte back.
// - Bank-access bit 0 resolves the address inside the fixed access bank.
// - Extended set, bank bit 0, address up to 95 uses indexed literal offset.
// - Decimal adjust adds 6 per nibble when above 9 or digit carry (low) / carry (high) set.
module dad_core (
  // Clock and reset
  input  wire logic                            sys_clk,
  input  wire logic                            sys_rst,
  // Instruction from decode stage
  input  wire logic                            instr_valid,
  input  wire logic [15:0]                     instr_word,
  output logic                                 instr_taken,
  // Addressing context
  input  wire logic [dad_pkg::BANK_W-1:0]      bank_select_register,
  input  wire logic                            ext_set_en,
  input  wire logic [dad_pkg::ADDR_W-1:0]      index_base,
  // Data memory read
  output logic                                 mem_rd_en,
  output logic [dad_pkg::ADDR_W-1:0]           mem_rd_addr,
  input  wire logic [dad_pkg::DATA_W-1:0]      mem_rd_data,
  // Data memory write
  output dad_pkg::dad_mem_wr_t                 mem_wr,
  // Loads from the rest of the core
  input  wire logic                            acc_load,
  input  wire logic [dad_pkg::DATA_W-1:0]      acc_load_data,
  input  wire logic                            flags_load,
  input  wire dad_pkg::dad_flags_t             flags_load_data,
  // State
  output dad_pkg::dad_phase_t                  q_phase,
  output logic [dad_pkg::DATA_W-1:0]           accumulator,
  output dad_pkg::dad_flags_t                  status_flags,
  output logic                                 instr_done
);
  import dad_pkg::*;

  dad_phase_t        phase_r;
  dad_phase_t        phase_nxt;
  dad_op_t           op_r;
  logic [15:0]       ir_r;
  logic [ADDR_W-1:0] addr_r;
  logic [7:0]        opnd_r;
  logic [7:0]        result_r;
  dad_flags_t        flags_res_r;
  logic [7:0]        acc_r;
  dad_flags_t        flags_r;
  logic              rd_en_r;
  dad_mem_wr_t       wr_r;
  logic              done_r;
  logic [7:0]        alu_result;
  dad_flags_t        alu_flags;

  function automatic dad_op_t decode_op(input logic [15:0] w);
    dad_op_t op;
    op = DAD_OP_NONE;
    if (w[OPC_HI:OPC_LO] == OPC_DEC) begin
      op = DAD_OP_DEC;
    end else if (w == OPC_DADJ) begin
      op = DAD_OP_DADJ;
    end
    return op;
  endfunction

  // Operand address resolution for byte instructions
  function automatic logic [ADDR_W-1:0] resolve_addr(
    input logic [7:0]        f,
    input logic              banked,
    input logic [BANK_W-1:0] bank,
    input logic              ext_en,
    input logic [ADDR_W-1:0] base
  );
    logic [ADDR_W-1:0] a;
    a = {ACC_LO_BANK, f};
    if (banked) begin
      a = {bank, f};
    end else if (ext_en && f <= ILO_LIMIT) begin
      a = base + {4'h0, f};
    end else if (f >= ACC_SPLIT) begin
      a = {ACC_HI_BANK, f};
    end else begin
      a = {ACC_LO_BANK, f};
    end
    return a;
  endfunction

  dad_alu dad_alu_inst (
    .op        (op_r),
    .opnd      (opnd_r),
    .flags_in  (flags_r),
    .result    (alu_result),
    .flags_out (alu_flags)
  );

  // Free-running quarter phases; one instruction cycle is four clocks
  always_comb begin
    unique case (phase_r)
      DAD_Q1: phase_nxt = DAD_Q2;
      DAD_Q2: phase_nxt = DAD_Q3;
      DAD_Q3: phase_nxt = DAD_Q4;
      DAD_Q4: phase_nxt = DAD_Q1;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      phase_r <= DAD_Q1;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // Instruction latched at the end of the decode phase
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ir_r   <= IR_RST;
      op_r   <= DAD_OP_NONE;
      addr_r <= {ADDR_W{1'b0}};
    end else if (phase_r == DAD_Q1) begin
      ir_r   <= instr_word;
      op_r   <= instr_valid ? decode_op(instr_word) : DAD_OP_NONE;
      addr_r <= resolve_addr(instr_word[FADDR_HI:0], instr_word[BANKED_BIT],
                             bank_select_register, ext_set_en, index_base);
    end
  end

  // read strobe in second phase
  // Decoded from the live word so memory sees the strobe in Q2
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rd_en_r <= 1'b0;
    end else begin
      rd_en_r <= (phase_r == DAD_Q1) && instr_valid &&
                 (decode_op(instr_word) == DAD_OP_DEC);
    end
  end

  // Operand capture; the accumulator is the operand of the adjust
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      opnd_r <= 8'h00;
    end else if (phase_r == DAD_Q2) begin
      opnd_r <= (op_r == DAD_OP_DEC) ? mem_rd_data : acc_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      result_r    <= 8'h00;
      flags_res_r <= FLAGS_RST;
    end else if (phase_r == DAD_Q3) begin
      result_r    <= alu_result;
      flags_res_r <= alu_flags;
    end
  end

  // memory write-back when destination bit set
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wr_r <= '0;
    end else if (phase_r == DAD_Q3) begin
      wr_r.en   <= (op_r == DAD_OP_DEC) && ir_r[DEST_BIT];
      wr_r.addr <= addr_r;
      wr_r.data <= alu_result;
    end else begin
      wr_r.en <= 1'b0;
    end
  end

  // accumulator destination; own write beats external load
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      acc_r <= ACC_RST;
    end else if (phase_r == DAD_Q4 &&
                 (op_r == DAD_OP_DADJ || (op_r == DAD_OP_DEC && !ir_r[DEST_BIT]))) begin
      acc_r <= result_r;
    end else if (acc_load) begin
      acc_r <= acc_load_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      flags_r <= FLAGS_RST;
    end else if (phase_r == DAD_Q4 && op_r != DAD_OP_NONE) begin
      flags_r <= flags_res_r;
    end else if (flags_load) begin
      flags_r <= flags_load_data;
    end
  end

  // Completion pulse in the cycle after the write phase
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      done_r <= 1'b0;
    end else begin
      done_r <= (phase_r == DAD_Q4) && (op_r != DAD_OP_NONE);
    end
  end

  // Handshake output is combinational; the rest come from flip-flops
  assign instr_taken  = (phase_r == DAD_Q1);
  assign mem_rd_en    = rd_en_r;
  assign mem_rd_addr  = addr_r;
  assign mem_wr       = wr_r;
  assign q_phase      = phase_r;
  assign accumulator  = acc_r;
  assign status_flags = flags_r;
  assign instr_done   = done_r;

endmodule

// *** logic/dad_pkg.sv ***
package dad_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int BANK_W = 4;

  // Opcode layout
  localparam logic [15:0] OPC_DADJ     = 16'h0007;
  localparam logic [5:0]  OPC_DEC      = 6'h01;
  localparam int          OPC_HI       = 15;
  localparam int          OPC_LO       = 10;
  localparam int          DEST_BIT     = 9;
  localparam int          BANKED_BIT   = 8;
  localparam int          FADDR_HI     = 7;

  // Access bank split and indexed window
  localparam logic [7:0]  ILO_LIMIT    = 8'h5f;
  localparam logic [7:0]  ACC_SPLIT    = 8'h60;
  localparam logic [3:0]  ACC_LO_BANK  = 4'h0;
  localparam logic [3:0]  ACC_HI_BANK  = 4'hf;

  // Arithmetic constants
  localparam logic [3:0]  BCD_MAX      = 4'h9;
  localparam logic [3:0]  BCD_FIX      = 4'h6;
  localparam logic [7:0]  DEC_OVF_SRC  = 8'h80;

  // Reset values
  localparam logic [7:0]  ACC_RST      = 8'h00;
  localparam logic [15:0] IR_RST       = 16'h0000;

  typedef enum logic [1:0] {
    DAD_Q1 = 2'b00,
    DAD_Q2 = 2'b01,
    DAD_Q3 = 2'b11,
    DAD_Q4 = 2'b10
  } dad_phase_t;

  typedef enum logic [1:0] {
    DAD_OP_NONE = 2'b00,
    DAD_OP_DADJ = 2'b01,
    DAD_OP_DEC  = 2'b10
  } dad_op_t;

  typedef struct packed {
    logic n;
    logic overflow_flag;
    logic z;
    logic digit_carry_flag;
    logic c;
  } dad_flags_t;

  localparam dad_flags_t FLAGS_RST = 5'h00;

  typedef struct packed {
    logic              en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } dad_mem_wr_t;

endpackage

// *** tb/dad_chk.sv ***
`timescale 1ns/10ps
module dad_chk
  import dad_pkg::*;
(
  // Clock, reset and inputs
  input wire logic              sys_clk,
  input wire logic              sys_rst,
  input wire logic              instr_valid,
  input wire logic [15:0]       instr_word,
  input wire logic [BANK_W-1:0] bank_select_register,
  input wire logic              ext_set_en,
  input wire logic [ADDR_W-1:0] index_base,
  input wire logic [DATA_W-1:0] mem_rd_data,
  // Outputs watched
  input wire logic              mem_rd_en,
  input wire logic [ADDR_W-1:0] mem_rd_addr,
  input wire dad_mem_wr_t       mem_wr,
  input wire dad_phase_t        q_phase,
  input wire logic [DATA_W-1:0] accumulator,
  input wire dad_flags_t        status_flags,
  input wire logic              instr_done
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire logic       dec = q_phase == DAD_Q1 && instr_valid && instr_word[15:10] == OPC_DEC;
  wire logic [7:0] f   = instr_word[7:0];
  wire logic       ilo = !instr_word[8] && ext_set_en && f <= ILO_LIMIT;
  a_read_q2: assert property (
    mem_rd_en |-> q_phase == DAD_Q2) else $error("read strobe outside Q2");
  a_write_q4: assert property (
    mem_wr.en |-> q_phase == DAD_Q4 && mem_wr.addr == mem_rd_addr) else $error("bad write");
  a_dec_read: assert property (
    dec |=> mem_rd_en) else $error("decrement not decoded");
  a_dest_mem: assert property (
    dec && instr_word[9] |-> ##3 mem_wr.en ##1 instr_done) else $error("no write back");
  a_dest_acc: assert property (
    dec && !instr_word[9] |-> ##3 !mem_wr.en ##1 accumulator == $past(mem_rd_data, 3) - 8'h01)
    else $error("accumulator result wrong");
  a_bank_access: assert property (
    dec && !instr_word[8] && !ilo |=> mem_rd_addr ==
      {($past(f) >= ACC_SPLIT) ? ACC_HI_BANK : ACC_LO_BANK, $past(f)})
    else $error("access bank address wrong");
  a_bank_select: assert property (
    dec && instr_word[8] |=> mem_rd_addr == {$past(bank_select_register), $past(f)})
    else $error("banked address wrong");
  a_indexed_addr: assert property (
    dec && ilo |=> mem_rd_addr == $past(index_base) + {4'h0, $past(f)})
    else $error("indexed address wrong");
  a_flag_zo: assert property (
    dec |-> ##4 status_flags.z == ($past(mem_rd_data, 3) == 8'h01)
      && status_flags.overflow_flag == ($past(mem_rd_data, 3) == DEC_OVF_SRC))
    else $error("zero or overflow flag wrong");
  c_dec_write: cover property (mem_wr.en);
  c_indexed: cover property (dec && ilo);
  c_dadj: cover property (q_phase == DAD_Q1 && instr_valid && instr_word == OPC_DADJ);
  c_acc_dest: cover property (dec && !instr_word[9]);
endmodule
bind dad_core dad_chk dad_chk_inst (.sys_clk, .sys_rst, .instr_valid, .instr_word,
  .bank_select_register, .ext_set_en, .index_base, .mem_rd_data, .mem_rd_en, .mem_rd_addr,
  .mem_wr, .q_phase, .accumulator, .status_flags, .instr_done);

// *** tb/dad_core_bench.sv ***
`timescale 1ns/10ps
module dad_core_bench;
  import dad_pkg::*;
  logic              sys_clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic              instr_valid = 1'b0;
  logic [15:0]       instr_word = 16'h0000;
  logic [BANK_W-1:0] bank_select_register = 4'h3;
  logic              ext_set_en = 1'b0;
  logic [ADDR_W-1:0] index_base = 12'hfe0;
  logic [DATA_W-1:0] mem_rd_data;
  logic [ADDR_W-1:0] mem_rd_addr;
  logic              mem_rd_en;
  dad_mem_wr_t       mem_wr;
  logic              acc_load = 1'b0;
  logic [DATA_W-1:0] acc_load_data = 8'h00;
  logic              flags_load = 1'b0;
  dad_flags_t        flags_load_data = 5'h00;
  dad_phase_t        q_phase;
  logic [DATA_W-1:0] accumulator;
  dad_flags_t        status_flags;
  logic              instr_taken;
  logic              instr_done;
  int                num_errors = 0;
  int                tests_run = 0;
  always #20 sys_clk = ~sys_clk;
  dad_core dad_core_inst (.sys_clk, .sys_rst, .instr_valid, .instr_word, .instr_taken,
    .bank_select_register, .ext_set_en, .index_base, .mem_rd_en, .mem_rd_addr, .mem_rd_data,
    .mem_wr, .acc_load, .acc_load_data, .flags_load, .flags_load_data, .q_phase,
    .accumulator, .status_flags, .instr_done);
  dad_mem dad_mem_inst (.sys_clk, .mem_rd_en, .mem_rd_addr, .mem_rd_data, .mem_wr);
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Loads ride the Q1 cycle so each call spans exactly one instruction cycle
  task automatic issue(logic [15:0] w, logic [7:0] a, dad_flags_t fl);
    acc_load = 1'b1;
    acc_load_data = a;
    flags_load = 1'b1;
    flags_load_data = fl;
    instr_valid = 1'b1;
    instr_word = w;
    check("taken q1", instr_taken, 1'b1);
    @(negedge sys_clk);
    check("taken q2", instr_taken, 1'b0);
    instr_valid = 1'b0;
    acc_load = 1'b0;
    flags_load = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask
  task automatic t_dec(logic [7:0] f, logic a, logic d, logic ext, logic [7:0] v,
                       logic [11:0] ea);
    logic [7:0] r;
    r = v - 8'h01;
    ext_set_en = ext;
    dad_mem_inst.mem[ea] = v;
    issue({OPC_DEC, d, a, f}, 8'h5a, 5'h00);
    check("dec mem", dad_mem_inst.mem[ea], d ? r : v);
    check("dec acc", accumulator, d ? 8'h5a : r);
    check("dec flags", status_flags,
          {r[7], v == 8'h80, r == 8'h00, v[3:0] != 4'h0, v != 8'h00});
    check("dec done", instr_done, 1'b1);
  endtask
  task automatic t_dadj(logic [7:0] v, logic c, logic dcf, logic [7:0] ev, logic ec);
    issue(OPC_DADJ, v, {3'h0, dcf, c});
    check("dadj acc", accumulator, ev);
    check("dadj flags", status_flags, {3'h0, dcf, ec});
    check("dadj done", instr_done, 1'b1);
  endtask
  // Unrecognised words must leave memory, accumulator and flags alone
  task automatic t_nop(logic [15:0] w, logic [11:0] ea);
    dad_mem_inst.mem[ea] = 8'h77;
    issue(w, 8'h33, 5'h1f);
    check("nop mem", dad_mem_inst.mem[ea], 8'h77);
    check("nop acc", accumulator, 8'h33);
    check("nop flags", status_flags, 5'h1f);
    check("nop done", instr_done, 1'b0);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge sys_clk);
    sys_rst = 1'b0;
    t_dec(8'h10, 1'b0, 1'b1, 1'b0, 8'h01, 12'h010);
    t_dec(8'h80, 1'b1, 1'b0, 1'b0, 8'h80, 12'h380);
    t_dec(8'h20, 1'b0, 1'b1, 1'b1, 8'h00, 12'h000);
    t_dec(8'h5f, 1'b0, 1'b0, 1'b1, 8'h10, 12'h03f);
    t_dec(8'h60, 1'b0, 1'b1, 1'b1, 8'hf0, 12'hf60);
    t_dadj(8'ha5, 1'b0, 1'b0, 8'h05, 1'b1);
    t_dadj(8'hce, 1'b0, 1'b0, 8'h34, 1'b1);
    t_dadj(8'h3b, 1'b0, 1'b0, 8'h41, 1'b0);
    t_dadj(8'h45, 1'b1, 1'b0, 8'ha5, 1'b1);
    t_dadj(8'h1a, 1'b0, 1'b1, 8'h20, 1'b0);
    t_nop(16'h2c10, 12'h010);
    t_nop(16'h0008, 12'h008);
    tally_and_finish();
  end
  // Run needs about 64 cycles; generous margin
  initial begin
    #20000;
    num_errors++;
    tally_and_finish();
  end
endmodule

// *** tb/dad_mem.sv ***
`timescale 1ns/10ps
module dad_mem
  import dad_pkg::*;
(
  // Clock
  input wire logic              sys_clk,
  // Read and write ports
  input wire logic              mem_rd_en,
  input wire logic [ADDR_W-1:0] mem_rd_addr,
  output logic     [DATA_W-1:0] mem_rd_data,
  input wire dad_mem_wr_t       mem_wr
);
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [DATA_W-1:0] last_r = 8'h00;
  // read in Q2; idle bus inverts so stale data is never trusted
  assign mem_rd_data = mem_rd_en ? mem[mem_rd_addr] : ~last_r;
  always @(posedge sys_clk) begin
    if (mem_rd_en) begin
      last_r <= mem[mem_rd_addr];
    end
    if (mem_wr.en) begin
      mem[mem_wr.addr] <= mem_wr.data;
    end
  end
endmodule
